// ===== common/pickup_feed_consts.svh
// Timing and field constants of the pickup and feed controller.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef PICKUP_FEED_CONSTS_SVH
`define PICKUP_FEED_CONSTS_SVH

// System clock rate in MHz
`define CLK_MHZ 100
// Lifter must reach the stack surface within this time
`define LIFT_TIMEOUT_US 3000
// Pickup solenoid energise time
`define SOL_HOLD_US 60
// Size code per switch setting {upper, middle, lower}, one nibble each
`define SIZE_SW_MAP 32'h76513240
// Sticky status bit positions
`define ST_SW_MISMATCH 0
`define ST_LIFT_FAIL 1
`define ST_CAS_EMPTY 2
`define ST_MAN_EMPTY 3
`define ST_LEN_MISMATCH 4
`define ST_WID_MISMATCH 5
`define ST_WIDTH 6

`endif

// ===== common/pickup_feed_pkg.sv
// Types shared by the pickup and feed controller.
// Assumes no other package is needed.
package pickup_feed_pkg;

  // Media size codes; the low eight are the codes the size switch selects
  typedef enum logic [3:0] {
    SIZE_NONE = 4'h0,
    SIZE_A4 = 4'h1,
    SIZE_LETTER = 4'h2,
    SIZE_B5 = 4'h3,
    SIZE_A5 = 4'h4,
    SIZE_EXECUTIVE = 4'h5,
    SIZE_LEGAL = 4'h6,
    SIZE_ENVELOPE = 4'h7,
    SIZE_CUSTOM = 4'h8
  } size_e;

  // Print modes chosen by the formatter
  typedef enum logic [2:0] {
    MODE_AUTO = 3'h0,
    MODE_NORMAL = 3'h1,
    MODE_HEAVY1 = 3'h2,
    MODE_HEAVY2 = 3'h3,
    MODE_LIGHT2 = 3'h4,
    MODE_TRANSPARENCY = 3'h5
  } mode_e;

  // Width sensor classification
  typedef enum logic [1:0] {
    WID_SMALL = 2'h0,
    WID_RIGHT = 2'h1,
    WID_LEFT = 2'h2,
    WID_REGULAR = 2'h3
  } width_e;

endpackage

// ===== verilog/sheet_length_meter.sv
// Sheet length meter: counts clock cycles while the top-of-page
// sensor sees media. Assumes the sensor input is synchronous.
`timescale 1ns/1ps

module sheet_length_meter #(
  parameter int LW = 24
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Sensor
  input wire logic i_top_sensor,
  // Result
  output logic [LW-1:0] o_length,
  output logic o_done,
  output logic o_busy
);

  logic [LW-1:0] cnt_reg;
  logic [LW-1:0] cnt_next;
  logic top_reg;
  logic done_reg;
  logic [LW-1:0] len_reg;
  wire logic lead_edge;
  wire logic trail_edge;
  wire logic cnt_max;

  // Edges of the sheet at the sensor
  assign lead_edge = i_top_sensor & ~top_reg;
  assign trail_edge = ~i_top_sensor & top_reg;
  assign cnt_max = &cnt_reg;

  // Count from leading edge, saturate on a jam-length sheet
  always_comb begin
    cnt_next = cnt_reg;
    if (lead_edge) begin
      cnt_next = {{(LW-1){1'b0}}, 1'b1};
    end else if (i_top_sensor && !cnt_max) begin
      cnt_next = cnt_reg + {{(LW-1){1'b0}}, 1'b1};
    end
  end

  // Latch the length when the trailing edge leaves
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg <= '0;
      top_reg <= 1'b0;
      done_reg <= 1'b0;
      len_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
      top_reg <= i_top_sensor;
      done_reg <= trail_edge;
      if (trail_edge) begin
        len_reg <= cnt_reg;
      end
    end
  end

  assign o_length = len_reg;
  assign o_done = done_reg;
  assign o_busy = top_reg;

endmodule

// ===== verilog/media_pickup_feed_control.sv
// Pickup and feed control: motor and solenoid sequencing, cassette
// size decode, stack lift, media presence, feed speed, length and
// width checks. Assumes one clock, synchronous sensor inputs and a
// formatter that clears status before its next command.
`timescale 1ns/1ps
`include "pickup_feed_consts.svh"

module media_pickup_feed_control #(
  parameter int DW = 16,
  parameter int LW = 24,
  parameter int LIFT_TIMEOUT_CYC = `LIFT_TIMEOUT_US * `CLK_MHZ,
  parameter int SOL_HOLD_CYC = `SOL_HOLD_US * `CLK_MHZ
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Formatter commands
  input wire logic i_cmd_cassette,
  input wire logic i_cmd_manual,
  input wire logic i_abort,
  input wire logic [3:0] i_req_size,
  input wire logic [2:0] i_print_mode,
  input wire logic i_full_speed_req,
  input wire logic i_sleep,
  input wire logic [`ST_WIDTH-1:0] i_status_clr,
  // Configuration
  input wire logic [DW-1:0] i_cas_pick_delay,
  input wire logic [DW-1:0] i_man_pick_delay,
  input wire logic [DW-1:0] i_width_gap,
  input wire logic [LW-1:0] i_long_threshold,
  // Sensors
  input wire logic [2:0] i_size_switch,
  input wire logic i_stack_sensor_1,
  input wire logic i_stack_sensor_2,
  input wire logic i_cas_media,
  input wire logic i_manual_tray_media,
  input wire logic i_top_sensor,
  input wire logic i_width_sensor_a,
  input wire logic i_width_sensor_b,
  // Actuators
  output logic o_feed_motor,
  output logic o_cas_solenoid,
  output logic o_manual_tray_solenoid,
  output logic o_lifter_motor,
  output logic o_full_speed,
  output logic o_speed_undefined,
  // Status to formatter
  output logic [3:0] o_cassette_size,
  output logic [1:0] o_width_class,
  output logic [LW-1:0] o_sheet_length,
  output logic o_length_valid,
  output logic o_busy,
  output logic [`ST_WIDTH-1:0] o_status
);

  typedef enum logic [4:0] {
    P_IDLE = 5'b00001,
    P_DELAY = 5'b00010,
    P_PICK = 5'b00100,
    P_FEED = 5'b01000,
    P_GAP = 5'b10000
  } pick_e;

  typedef enum logic [3:0] {
    L_IDLE = 4'b0001,
    L_LIFT = 4'b0010,
    L_HOLD = 4'b0100,
    L_FAIL = 4'b1000
  } lift_e;

  // Decode the size switch: upper, middle, lower
  function automatic pickup_feed_pkg::size_e size_of(input logic [2:0] sw);
    return pickup_feed_pkg::size_e'(4'(`SIZE_SW_MAP >> {sw, 2'b00}));
  endfunction

  // Large class: A4, letter, legal
  function automatic logic is_large(input logic [3:0] s);
    return (s == pickup_feed_pkg::SIZE_A4) ||
           (s == pickup_feed_pkg::SIZE_LETTER) ||
           (s == pickup_feed_pkg::SIZE_LEGAL);
  endfunction

  // Sizes that carry a length and width class
  function automatic logic is_classed(input logic [3:0] s);
    return (s != pickup_feed_pkg::SIZE_NONE) &&
           (s != pickup_feed_pkg::SIZE_CUSTOM);
  endfunction

  pick_e pick_reg;
  pick_e pick_next;
  lift_e lift_reg;
  lift_e lift_next;
  logic [DW:0] tmr_reg;
  logic [DW:0] tmr_next;
  logic [31:0] lift_cnt_reg;
  logic src_cas_reg;
  logic [3:0] size_reg;
  logic [3:0] req_reg;
  logic [1:0] wid_reg;
  logic full_reg;
  logic undef_reg;
  logic present_reg;
  logic boot_reg;
  logic [`ST_WIDTH-1:0] st_reg;
  logic [`ST_WIDTH-1:0] st_set;
  logic [LW-1:0] len_w;
  logic len_done;
  logic len_busy;

  wire pickup_feed_pkg::size_e sw_size;
  wire logic cmd_ok;
  wire logic start_cas;
  wire logic start_man;
  wire logic tmr_zero;
  wire logic [DW:0] gap_cycles;
  wire logic [1:0] wid_now;
  wire logic lift_start;
  wire logic lift_to;
  wire logic len_long;
  wire logic wid_large;
  wire logic wid_classed;
  wire logic mode_full_ok;
  wire logic mode_auto;

  sheet_length_meter #(
    .LW(LW)
  ) u_len (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_top_sensor(i_top_sensor),
    .o_length(len_w),
    .o_done(len_done),
    .o_busy(len_busy)
  );

  // Switch decode and command acceptance
  assign sw_size = size_of(i_size_switch);
  assign cmd_ok = (pick_reg == P_IDLE) && (st_reg == '0);
  assign start_cas = cmd_ok && i_cmd_cassette;
  assign start_man = cmd_ok && i_cmd_manual && !i_cmd_cassette;
  assign tmr_zero = (tmr_reg == '0);

  // Width sensors: a is sensor 1, b is sensor 2
  assign wid_now = {i_width_sensor_a, i_width_sensor_b};
  assign wid_large = (wid_reg == pickup_feed_pkg::WID_REGULAR);
  assign wid_classed = (wid_reg == pickup_feed_pkg::WID_REGULAR) ||
                       (wid_reg == pickup_feed_pkg::WID_SMALL);

  // Gap before the next pickup grows off the regular width
  assign gap_cycles = (wid_reg == pickup_feed_pkg::WID_REGULAR) ? '0 :
                      (wid_reg == pickup_feed_pkg::WID_SMALL) ?
                      {1'b0, i_width_gap} : {i_width_gap, 1'b0};

  // Pickup sequencer
  always_comb begin
    pick_next = pick_reg;
    tmr_next = tmr_reg;
    if (!tmr_zero) begin
      tmr_next = tmr_reg - {{DW{1'b0}}, 1'b1};
    end
    unique case (pick_reg)
      P_IDLE: begin
        if (start_cas) begin
          pick_next = P_DELAY;
          tmr_next = {1'b0, i_cas_pick_delay};
        end else if (start_man) begin
          pick_next = P_DELAY;
          tmr_next = {1'b0, i_man_pick_delay};
        end
      end
      P_DELAY: begin
        if (tmr_zero) begin
          pick_next = P_PICK;
          tmr_next = (DW+1)'(SOL_HOLD_CYC - 1);
        end
      end
      P_PICK: begin
        if (tmr_zero) begin
          pick_next = P_FEED;
        end
      end
      P_FEED: begin
        if (len_done) begin
          pick_next = P_GAP;
          tmr_next = gap_cycles;
        end
      end
      P_GAP: begin
        if (tmr_zero) begin
          pick_next = P_IDLE;
        end
      end
    endcase
    if (i_abort) begin
      pick_next = P_IDLE;
      tmr_next = '0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      pick_reg <= P_IDLE;
      tmr_reg <= '0;
    end else begin
      pick_reg <= pick_next;
      tmr_reg <= tmr_next;
    end
  end

  // Job attributes captured at command time
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      src_cas_reg <= 1'b0;
      req_reg <= '0;
      full_reg <= 1'b0;
      undef_reg <= 1'b0;
    end else if (start_cas || start_man) begin
      src_cas_reg <= start_cas;
      req_reg <= i_req_size;
      full_reg <= i_full_speed_req && mode_full_ok;
      undef_reg <= mode_auto;
    end
  end

  // Speed table: full only for large sizes in permitted modes
  assign mode_auto = (i_print_mode == pickup_feed_pkg::MODE_AUTO);
  assign mode_full_ok = is_large(i_req_size) &&
    ((i_print_mode == pickup_feed_pkg::MODE_NORMAL) ||
     (i_print_mode == pickup_feed_pkg::MODE_HEAVY1) ||
     (i_print_mode == pickup_feed_pkg::MODE_LIGHT2));

  // Lift triggers: boot, cassette inserted
  assign lift_start = boot_reg || (sw_size != pickup_feed_pkg::SIZE_NONE &&
                                   !present_reg);
  assign lift_to = (lift_cnt_reg >= 32'(LIFT_TIMEOUT_CYC));

  // Stack lift sequencer
  always_comb begin
    lift_next = lift_reg;
    unique case (lift_reg)
      L_IDLE: begin
        if (lift_start && sw_size != pickup_feed_pkg::SIZE_NONE) begin
          lift_next = L_LIFT;
        end
      end
      L_LIFT: begin
        if (i_stack_sensor_2) begin
          lift_next = L_HOLD;
        end else if (lift_to) begin
          lift_next = i_stack_sensor_1 ? L_HOLD : L_FAIL;
        end
      end
      L_HOLD: begin
        if (!i_stack_sensor_1) begin
          lift_next = L_LIFT;
        end
      end
      L_FAIL: begin
        if (i_status_clr[`ST_LIFT_FAIL]) begin
          lift_next = L_IDLE;
        end
      end
    endcase
    if (sw_size == pickup_feed_pkg::SIZE_NONE) begin
      lift_next = (lift_reg == L_FAIL) ? L_FAIL : L_IDLE;
    end
  end

  // Lift timer restarts on each motor start
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      lift_reg <= L_IDLE;
      lift_cnt_reg <= '0;
      boot_reg <= 1'b1;
      present_reg <= 1'b0;
    end else begin
      lift_reg <= lift_next;
      boot_reg <= 1'b0;
      present_reg <= (sw_size != pickup_feed_pkg::SIZE_NONE);
      if (lift_next == L_LIFT && lift_reg != L_LIFT) begin
        lift_cnt_reg <= '0;
      end else if (lift_reg == L_LIFT && !lift_to) begin
        lift_cnt_reg <= lift_cnt_reg + 32'h00000001;
      end
    end
  end

  // Length class from measured time
  assign len_long = (len_w >= i_long_threshold);

  // Fault and mismatch events
  always_comb begin
    st_set = '0;
    st_set[`ST_SW_MISMATCH] = start_cas && (i_req_size != 4'(sw_size));
    st_set[`ST_LIFT_FAIL] = (lift_reg == L_LIFT) && lift_to &&
                            !i_stack_sensor_2 && !i_stack_sensor_1;
    st_set[`ST_CAS_EMPTY] = !i_sleep && !i_cas_media;
    st_set[`ST_MAN_EMPTY] = !i_sleep && !i_manual_tray_media;
    st_set[`ST_LEN_MISMATCH] = len_done && (pick_reg == P_FEED) &&
      ((is_classed(req_reg) && (len_long != is_large(req_reg))) ||
       (src_cas_reg && is_classed(4'(sw_size)) &&
        (len_long != is_large(4'(sw_size)))));
    st_set[`ST_WID_MISMATCH] = len_done && (pick_reg == P_FEED) && wid_classed &&
      ((is_classed(req_reg) && (wid_large != is_large(req_reg))) ||
       (src_cas_reg && is_classed(4'(sw_size)) &&
        (wid_large != is_large(4'(sw_size)))));
  end

  // Sticky status: a new event beats a clear in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= (st_reg & ~i_status_clr) | st_set;
    end
  end

  // Width sample while the sheet covers the top sensor
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      wid_reg <= pickup_feed_pkg::WID_REGULAR;
      size_reg <= '0;
    end else begin
      size_reg <= 4'(sw_size);
      if (i_top_sensor && len_busy) begin
        wid_reg <= wid_now;
      end
    end
  end

  // Actuator drive
  assign o_feed_motor = (pick_reg != P_IDLE) && (pick_reg != P_GAP);
  assign o_cas_solenoid = (pick_reg == P_PICK) && src_cas_reg;
  assign o_manual_tray_solenoid = (pick_reg == P_PICK) && !src_cas_reg;
  assign o_lifter_motor = (lift_reg == L_LIFT);
  assign o_full_speed = full_reg;
  assign o_speed_undefined = undef_reg;

  // Status outputs
  assign o_cassette_size = size_reg;
  assign o_width_class = wid_reg;
  assign o_sheet_length = len_w;
  assign o_length_valid = len_done;
  assign o_busy = (pick_reg != P_IDLE);
  assign o_status = st_reg;

endmodule

// ===== tb/media_pickup_feed_control_checker.sv
// Checker of the pickup and feed controller, on its top ports.
// Assumes it is bound to every instance of the controller.
`timescale 1ns/1ps
`include "pickup_feed_consts.svh"

module media_pickup_feed_control_checker #(
  parameter int LIFT_TIMEOUT_CYC = 300000
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Formatter side
  input wire logic i_cmd_cassette, i_cmd_manual, i_full_speed_req, i_sleep,
  input wire logic [3:0] i_req_size,
  input wire logic [2:0] i_print_mode,
  input wire logic [`ST_WIDTH-1:0] i_status_clr,
  // Sensors
  input wire logic [2:0] i_size_switch,
  input wire logic i_stack_sensor_1, i_stack_sensor_2, i_cas_media, i_manual_tray_media,
  // Controller outputs
  input wire logic o_feed_motor, o_cas_solenoid, o_manual_tray_solenoid, o_lifter_motor,
  input wire logic o_full_speed, o_speed_undefined, o_busy,
  input wire logic [3:0] o_cassette_size,
  input wire logic [`ST_WIDTH-1:0] o_status
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  // Size per switch code, one nibble per code
  localparam logic [31:0] SIZE_MAP = 32'h76513240;
  logic acc, full_ok;
  logic [3:0] exp_size;
  logic [`ST_WIDTH-1:0] keep;
  logic [31:0] lift_cnt;
  // Command acceptance, speed entitlement, decode and kept status
  assign acc = (i_cmd_cassette | i_cmd_manual) & ~o_busy & (o_status == '0);
  assign full_ok = i_full_speed_req & (i_req_size inside {4'h1, 4'h2, 4'h6})
    & (i_print_mode inside {3'h1, 3'h2, 3'h4});
  assign exp_size = SIZE_MAP[{i_size_switch, 2'b00} +: 4];
  assign keep = o_status & ~i_status_clr;
  // Cycles the lifter has run without a pause
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      lift_cnt <= '0;
    end else begin
      lift_cnt <= o_lifter_motor ? lift_cnt + 1 : '0;
    end
  end

  a_cmd_start: assert property (acc |=> o_feed_motor && o_busy)
    else $error("accepted command did not start motor");
  a_pick_motor: assert property ((o_cas_solenoid || o_manual_tray_solenoid) |->
    o_feed_motor && !(o_cas_solenoid && o_manual_tray_solenoid))
    else $error("pickup solenoid without motor");
  a_size_decode: assert property (1 |=> o_cassette_size == $past(exp_size))
    else $error("size switch decode wrong");
  a_switch_flag: assert property (acc && i_cmd_cassette && i_req_size != o_cassette_size
    |=> o_status[`ST_SW_MISMATCH]) else $error("switch mismatch not flagged");
  a_lift_stop: assert property (o_lifter_motor && i_stack_sensor_1 && i_stack_sensor_2
    |=> !o_lifter_motor) else $error("lifter ran past surface");
  a_lift_restart: assert property ($fell(i_stack_sensor_1) && !o_lifter_motor
    && !o_status[`ST_LIFT_FAIL] && i_size_switch != 3'h0 |=> o_lifter_motor)
    else $error("lifter not restarted");
  a_lift_fail: assert property ($fell(o_lifter_motor) && !i_stack_sensor_1
    && !i_stack_sensor_2 && i_size_switch != 3'h0 |-> ##[0:1] o_status[`ST_LIFT_FAIL])
    else $error("lifter stopped without fault");
  a_lift_bound: assert property (lift_cnt <= LIFT_TIMEOUT_CYC + 1)
    else $error("lifter ran past timeout");
  a_cas_absent: assert property (!i_sleep && !i_cas_media |=> o_status[`ST_CAS_EMPTY])
    else $error("cassette empty not flagged");
  a_man_absent: assert property (!i_sleep && !i_manual_tray_media |=> o_status[3])
    else $error("manual tray empty not flagged");
  a_status_sticky: assert property (1 |=> (o_status & $past(keep)) == $past(keep))
    else $error("status bit lost without clear");
  a_refuse_cmd: assert property ((i_cmd_cassette || i_cmd_manual) && !o_busy
    && o_status != '0 |=> !o_busy) else $error("command taken with status set");
  a_speed_pick: assert property (acc |=> o_full_speed == $past(full_ok)
    && o_speed_undefined == $past(i_print_mode == 3'h0)) else $error("feed speed wrong");
endmodule

bind media_pickup_feed_control media_pickup_feed_control_checker #(
  .LIFT_TIMEOUT_CYC(LIFT_TIMEOUT_CYC)
) u_checker (
  .i_clk_sys, .i_nrst, .i_cmd_cassette, .i_cmd_manual, .i_full_speed_req, .i_sleep,
  .i_req_size, .i_print_mode, .i_status_clr, .i_size_switch, .i_stack_sensor_1,
  .i_stack_sensor_2, .i_cas_media, .i_manual_tray_media, .o_feed_motor, .o_cas_solenoid,
  .o_manual_tray_solenoid, .o_lifter_motor, .o_full_speed, .o_speed_undefined, .o_busy,
  .o_cassette_size, .o_status
);

// ===== tb/formatter_model.sv
// Formatter model: issues print commands and clears sticky status.
// Assumes the controller's busy and status outputs and one clock.
`timescale 1ns/1ps
`include "pickup_feed_consts.svh"

module formatter_model (
  // Clock and controller state
  input wire logic i_clk_sys,
  input wire logic i_busy,
  input wire logic [`ST_WIDTH-1:0] i_status,
  // Commands to the controller
  output logic o_cmd_cassette,
  output logic o_cmd_manual,
  output logic [3:0] o_req_size,
  output logic [2:0] o_print_mode,
  output logic o_full_speed_req,
  output logic [`ST_WIDTH-1:0] o_status_clr
);
  // Idle levels
  initial begin
    {o_cmd_cassette, o_cmd_manual, o_full_speed_req} = 3'h0;
    o_req_size = 4'h0;
    o_print_mode = 3'h0;
    o_status_clr = '0;
  end

  // One-cycle clear of every status bit
  task automatic clr_all;
    o_status_clr = '1;
    @(posedge i_clk_sys);
    #1;
    o_status_clr = '0;
  endtask

  // Wait for idle, clear faults unless told not to, then pulse a command
  task automatic cmd(input logic cas, input logic [3:0] size, input logic [2:0] mode,
                     input logic full, input logic clr);
    for (int n = 0; n < 500 && i_busy !== 1'b0; n++) begin
      @(posedge i_clk_sys);
      #1;
    end
    if (clr && i_status != '0) clr_all();
    o_req_size = size;
    o_print_mode = mode;
    o_full_speed_req = full;
    {o_cmd_cassette, o_cmd_manual} = {cas, ~cas};
    @(posedge i_clk_sys);
    #1;
    {o_cmd_cassette, o_cmd_manual} = 2'h0;
    // Qualifiers only count with the command, so scramble them after
    o_req_size = ~size;
    o_print_mode = ~mode;
    o_full_speed_req = ~full;
  endtask
endmodule

// ===== tb/media_pickup_feed_control_tb.sv
// Testbench of the pickup and feed controller with a formatter model.
// Assumes the package, the model and the bound checker are compiled.
`timescale 1ns/1ps
`include "pickup_feed_consts.svh"

module media_pickup_feed_control_tb;
  localparam int LIFT = 50;
  localparam int SOL = 4;
  localparam logic [15:0] DCAS = 16'h0005;
  localparam logic [15:0] DMAN = 16'h0007;
  localparam logic [15:0] GAP = 16'h0006;
  // Stimulus, sensors and observed outputs
  logic i_clk_sys = 1'b0, i_nrst = 1'b0, i_sleep = 1'b0, i_top_sensor = 1'b0;
  logic i_stack_sensor_1 = 1'b1, i_stack_sensor_2 = 1'b1, i_cas_media = 1'b1;
  logic i_manual_tray_media = 1'b1, i_width_sensor_a = 1'b1, i_width_sensor_b = 1'b1;
  logic [2:0] i_size_switch = 3'h4;
  logic i_abort = 1'b0;
  wire i_cmd_cassette, i_cmd_manual, i_full_speed_req;
  wire [3:0] i_req_size;
  wire [2:0] i_print_mode;
  wire [`ST_WIDTH-1:0] i_status_clr, o_status;
  wire o_feed_motor, o_cas_solenoid, o_manual_tray_solenoid, o_lifter_motor, o_full_speed;
  wire o_speed_undefined, o_length_valid, o_busy;
  wire [3:0] o_cassette_size;
  wire [1:0] o_width_class;
  wire [23:0] o_sheet_length;
  logic [3:0] exp_sz [8] = '{4'h0, 4'h4, 4'h2, 4'h3, 4'h1, 4'h5, 4'h6, 4'h7};
  int bad_count = 0, check_count = 0, ng, n0;

  media_pickup_feed_control #(.LIFT_TIMEOUT_CYC(LIFT), .SOL_HOLD_CYC(SOL)) DUT (
    .i_clk_sys, .i_nrst, .i_cmd_cassette, .i_cmd_manual, .i_abort, .i_req_size,
    .i_print_mode, .i_full_speed_req, .i_sleep, .i_status_clr, .i_cas_pick_delay(DCAS),
    .i_man_pick_delay(DMAN), .i_width_gap(GAP), .i_long_threshold(24'h000014),
    .i_size_switch, .i_stack_sensor_1, .i_stack_sensor_2, .i_cas_media,
    .i_manual_tray_media, .i_top_sensor, .i_width_sensor_a, .i_width_sensor_b,
    .o_feed_motor, .o_cas_solenoid, .o_manual_tray_solenoid, .o_lifter_motor, .o_full_speed,
    .o_speed_undefined, .o_cassette_size, .o_width_class, .o_sheet_length, .o_length_valid,
    .o_busy, .o_status);
  formatter_model FMT (.i_clk_sys, .i_busy(o_busy), .i_status(o_status),
    .o_cmd_cassette(i_cmd_cassette), .o_cmd_manual(i_cmd_manual), .o_req_size(i_req_size),
    .o_print_mode(i_print_mode), .o_full_speed_req(i_full_speed_req),
    .o_status_clr(i_status_clr));

  // Clock
  always #5 i_clk_sys = ~i_clk_sys;

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Step n edges, then settle past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  // Solenoid timing after an accepted command
  task automatic pick(input logic c, input int d);
    check("start", o_feed_motor & o_busy, 1'b1);
    cyc(d);
    check("early", o_cas_solenoid | o_manual_tray_solenoid, 1'b0);
    cyc(1);
    check("pick", {o_cas_solenoid, o_manual_tray_solenoid}, {c, ~c});
    cyc(SOL);
    check("drop", o_cas_solenoid | o_manual_tray_solenoid, 1'b0);
  endtask
  // One sheet past the top sensor; ng ends as cycles from result to idle
  task automatic sheet(input int len, input logic [1:0] w);
    {i_width_sensor_a, i_width_sensor_b} = w;
    i_top_sensor = 1'b1;
    cyc(len);
    i_top_sensor = 1'b0;
    {i_width_sensor_a, i_width_sensor_b} = ~w;
    for (ng = 0; ng < 8 && o_length_valid !== 1'b1; ng++) cyc(1);
    check("valid", o_length_valid, 1'b1);
    check("length", o_sheet_length, len);
    check("width", o_width_class, w);
    for (ng = 0; ng < 99 && o_busy !== 1'b0; ng++) cyc(1);
  endtask

  task automatic t_boot;
    cyc(11);
    check("reset", {o_width_class, o_status, o_feed_motor, o_lifter_motor, o_busy}, 11'h600);
    cyc(1);
    i_nrst = 1'b1;
    cyc(1);
    check("boot lift", o_lifter_motor, 1'b1);
    cyc(2);
    check("boot stop", o_lifter_motor, 1'b0);
  endtask
  task automatic t_decode;
    for (int s = 0; s < 8; s++) begin
      i_size_switch = 3'(s);
      cyc(2);
      check("size", o_cassette_size, exp_sz[s]);
    end
  endtask
  task automatic t_lift;
    i_size_switch = 3'h0;
    cyc(2);
    {i_stack_sensor_1, i_stack_sensor_2} = 2'h0;
    i_size_switch = 3'h4;
    cyc(2);
    check("insert lift", o_lifter_motor, 1'b1);
    {i_stack_sensor_1, i_stack_sensor_2} = 2'h3;
    cyc(2);
    check("surface", o_lifter_motor, 1'b0);
    {i_stack_sensor_1, i_stack_sensor_2} = 2'h0;
    cyc(2);
    check("relift", o_lifter_motor, 1'b1);
    cyc(LIFT + 2);
    check("lift fail", {o_lifter_motor, o_status[`ST_LIFT_FAIL]}, 2'h1);
    {i_stack_sensor_1, i_stack_sensor_2} = 2'h3;
  endtask
  // Every print mode on A4, every width class
  task automatic t_modes;
    logic [1:0] w;
    for (int m = 0; m < 6; m++) begin
      w = 2'h3 - 2'(m);
      FMT.cmd(1'b1, 4'h1, 3'(m), 1'b1, 1'b1);
      pick(1'b1, DCAS);
      check("full", o_full_speed, m == 1 || m == 2 || m == 4);
      check("auto", o_speed_undefined, m == 0);
      check("sw ok", o_status[`ST_SW_MISMATCH], 1'b0);
      sheet(30, w);
      if (m == 0) n0 = ng;
      check("gap", ng - n0, (w == 2'h3) ? 0 : (w == 2'h0) ? GAP : 2 * GAP);
      check("wid flag", o_status[`ST_WID_MISMATCH], w == 2'h0);
      check("len ok", o_status[`ST_LEN_MISMATCH], 1'b0);
    end
  endtask
  task automatic t_manual;
    FMT.cmd(1'b0, 4'h3, 3'h1, 1'b1, 1'b1);
    pick(1'b0, DMAN);
    check("small half", o_full_speed, 1'b0);
    sheet(40, 2'h0);
    check("len flag", o_status[5:4], 2'h1);
    FMT.cmd(1'b1, 4'h1, 3'h1, 1'b1, 1'b0);
    cyc(2);
    check("refused", {o_busy, o_status[`ST_LEN_MISMATCH]}, 2'h1);
    FMT.cmd(1'b1, 4'h2, 3'h3, 1'b1, 1'b1);
    check("sw flag", o_status[`ST_SW_MISMATCH], 1'b1);
    check("heavy half", o_full_speed, 1'b0);
    sheet(30, 2'h3);
    // Abort during the pickup delay drops the job at once
    FMT.cmd(1'b0, 4'h3, 3'h1, 1'b0, 1'b1);
    i_abort = 1'b1;
    cyc(1);
    i_abort = 1'b0;
    check("abort", {o_busy, o_feed_motor, o_manual_tray_solenoid}, 3'h0);
  endtask
  task automatic t_presence;
    i_sleep = 1'b1;
    {i_cas_media, i_manual_tray_media} = 2'h0;
    FMT.clr_all();
    cyc(2);
    check("asleep", o_status[3:2], 2'h0);
    i_sleep = 1'b0;
    cyc(2);
    check("absent", o_status[3:2], 2'h3);
    i_cas_media = 1'b1;
    cyc(2);
    check("held", o_status[3:2], 2'h3);
    FMT.clr_all();
    check("cleared", o_status[3:2], 2'h2);
  endtask

  // Verdict and end of run
  task automatic tally_and_finish;
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    t_boot();
    t_decode();
    t_lift();
    t_modes();
    t_manual();
    t_presence();
    tally_and_finish();
  end
  // Watchdog, well beyond the several hundred cycles the run needs
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
endmodule
